//--- common/gan_pkg.sv
// Purpose: shared constants for the gigabit auto-negotiation register group
// Assumes: 16-bit registers, one per aligned 32-bit APB word
// Notes: printed offsets are word indices; byte address is four times the index
package gan_pkg;
  // register indices
  localparam logic [15:0] IDX_NP_TX = 16'hFFE7;
  localparam logic [15:0] IDX_NP_RX = 16'hFFE8;
  localparam logic [15:0] IDX_GB_CTRL = 16'hFFE9;
  localparam logic [15:0] IDX_GB_STAT = 16'hFFEA;
  localparam logic [15:0] IDX_EXT_STAT = 16'hFFEF;
  localparam logic [15:0] IDX_EXT_CTRL = 16'hFFF0;
  localparam int ADDR_W = 18;
  // byte addresses
  localparam logic [17:0] A_NP_TX = {IDX_NP_TX, 2'b00};
  localparam logic [17:0] A_NP_RX = {IDX_NP_RX, 2'b00};
  localparam logic [17:0] A_GB_CTRL = {IDX_GB_CTRL, 2'b00};
  localparam logic [17:0] A_GB_STAT = {IDX_GB_STAT, 2'b00};
  localparam logic [17:0] A_EXT_STAT = {IDX_EXT_STAT, 2'b00};
  localparam logic [17:0] A_EXT_CTRL = {IDX_EXT_CTRL, 2'b00};
  // next page transmit fields
  localparam int NP_MORE = 15;
  localparam int NP_FMT = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOG = 11;
  localparam logic [15:0] NP_TX_RST = 16'h2001;
  localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
  localparam logic [15:0] NP_RX_RST = 16'h0000;
  // gigabit control fields
  localparam int GC_TM_LSB = 13;
  localparam int GC_MAN_EN = 12;
  localparam int GC_MAN_VAL = 11;
  localparam int GC_SWITCH = 10;
  localparam int GC_ADV_FDX = 9;
  localparam int GC_ADV_HDX = 8;
  localparam logic [15:0] GC_RST = 16'h0300;
  localparam logic [15:0] GC_WMASK = 16'hFF00;
  localparam logic [2:0] TM_NORMAL = 3'h0;
  // gigabit status fields
  localparam int GS_FAULT = 15;
  localparam logic [7:0] IDLE_MAX = 8'hFF;
  localparam logic [7:0] IDLE_RST = 8'h00;
  // fixed capability word
  localparam logic [15:0] EXT_STAT_VAL = 16'h3000;
  // extended control
  localparam int EC_SCR_RST = 6;
  localparam logic [15:0] EXT_CTRL_RST = 16'h0000;
  localparam logic [15:0] EXT_CTRL_WMASK = 16'hFFBF;
  // strap settle cycles after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

//--- common/role_if.sv
// Purpose: carries role resolution inputs and results between modules
// Assumes: all signals on pclk
// Notes: resolve is a one-cycle pulse
`timescale 1ns/100ps
interface role_if;
  logic resolve;
  logic loc_manual;
  logic loc_value;
  logic loc_switch;
  logic [10:0] loc_seed;
  logic lp_manual;
  logic lp_value;
  logic lp_switch;
  logic [10:0] lp_seed;
  logic is_master;
  logic fault;
  logic clean;
  modport ctrl (
    output resolve, loc_manual, loc_value, loc_switch, loc_seed,
    output lp_manual, lp_value, lp_switch, lp_seed,
    input is_master, fault, clean
  );
  modport res (
    input resolve, loc_manual, loc_value, loc_switch, loc_seed,
    input lp_manual, lp_value, lp_switch, lp_seed,
    output is_master, fault, clean
  );
endinterface

//--- rtl/role_resolver.sv
// Purpose: master/slave role resolution at negotiation completion
// Assumes: resolve pulses once per completed negotiation
// Notes: equal seeds with equal port types are reported as a fault
`timescale 1ns/100ps
module role_resolver (
  input wire logic pclk,
  input wire logic presetn,
  role_if.res rif
);
  logic master_q;
  logic fault_q;
  logic clean_q;
  logic master_d;
  logic bad_d;

  always_comb begin
    master_d = master_q;
    bad_d = 1'b0;
    if (rif.loc_manual && rif.lp_manual) begin
      bad_d = (rif.loc_value == rif.lp_value);
      master_d = rif.loc_value;
    end else if (rif.loc_manual) begin
      master_d = rif.loc_value;
    end else if (rif.lp_manual) begin
      master_d = !rif.lp_value;
    end else if (rif.loc_switch != rif.lp_switch) begin
      master_d = rif.loc_switch;
    end else if (rif.loc_seed != rif.lp_seed) begin
      master_d = (rif.loc_seed > rif.lp_seed);
    end else begin
      bad_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_q <= 1'b0;
      fault_q <= 1'b0;
      clean_q <= 1'b0;
    end else begin
      fault_q <= rif.resolve & bad_d;
      clean_q <= rif.resolve & !bad_d;
      // a failed resolution keeps the previous role
      if (rif.resolve && !bad_d) begin
        master_q <= master_d;
      end
    end
  end

  assign rif.is_master = master_q;
  assign rif.fault = fault_q;
  assign rif.clean = clean_q;
endmodule

//--- rtl/gigabit_copper_autoneg_regs.sv
// Purpose: APB register group for next-page exchange and gigabit control/status
// Assumes: negotiation engine inputs are on pclk; strap pins are asynchronous
// Notes: one wait state per APB transfer; reads clear at data capture
`timescale 1ns/100ps
// Functional notes
// - formatted-page bit 13 resets to 1 and reads back last write
// - compliance bit 12 is sent to partner and reads back as written
// - hardware toggles read-only bit 11 per new exchange; resets to 0
// - bits 10:0 hold message code or data; reset value 001h
// - received page shows partner more-pages, acknowledge, formatted flags; reset 0
// - received page shows partner compliance, toggle and code bits 10:0
// - 3-bit test mode field selects transmit test; reset 000
// - control bit 12 selects manual role, else automatic resolution
// - manual role bit 11: 1 master, 0 slave; reads back last write
// - bit 10 advertises switch port; switch facing end-station becomes master
// - bits 9 and 8 advertise gigabit full and half duplex
// - status bit 15 latches role fault; clears on read, restart, clean completion
// - status bit 14 shows resolved role, 1 master
// - status bits 13 and 12 show local and remote receiver OK
// - status bits 11 and 10 show partner gigabit full and half duplex
// - idle error count counts while local receiver OK, clears on read, saturates
// - extended status reads fixed 0,0,1,1 in bits 15 to 12
module gigabit_copper_autoneg_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic manual_role_strap,
  input wire logic switch_port_strap,
  input wire logic an_restart,
  input wire logic an_complete,
  input wire logic np_tx_taken,
  input wire logic np_rx_valid,
  input wire logic [15:0] np_rx_word,
  input wire logic lp_manual,
  input wire logic lp_value,
  input wire logic lp_switch,
  input wire logic [10:0] lp_seed,
  input wire logic [10:0] loc_seed,
  input wire logic lp_adv_fdx,
  input wire logic lp_adv_hdx,
  input wire logic loc_rcvr_ok,
  input wire logic rem_rcvr_ok,
  input wire logic idle_err,
  output logic [15:0] np_tx_word,
  output logic [2:0] test_mode,
  output logic role_manual,
  output logic role_value,
  output logic switch_port,
  output logic adv_fdx,
  output logic adv_hdx,
  output logic is_master,
  output logic [15:0] ext_ctrl,
  output logic scrambler_reset
);

  // merge write data into a 16-bit register by byte lanes
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // only the writable bits of a register take new data
  function automatic logic [15:0] masked(
    input logic [15:0] old,
    input logic [15:0] nw,
    input logic [15:0] mask
  );
    return (nw & mask) | (old & ~mask);
  endfunction

  logic [1:0] man_sync_q;
  logic [1:0] sw_sync_q;
  logic [1:0] strap_cnt_q;
  logic strap_load;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic take;
  logic done;
  logic [15:0] rdata_d;
  logic hit_d;

  logic wr_np;
  logic wr_gc;
  logic wr_ec;
  logic rd_stat;

  logic [15:0] np_tx_q;
  logic [15:0] np_rx_q;
  logic [15:0] gc_q;
  logic fault_q;
  logic [7:0] idle_cnt_q;
  logic idle_inc;
  logic [15:0] ec_q;
  logic scr_rst_q;
  logic [15:0] ec_wr_d;
  logic [15:0] stat_word;

  role_if rif();

  // straps are pins: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_sync_q <= 2'b00;
      sw_sync_q <= 2'b00;
    end else begin
      man_sync_q <= {man_sync_q[0], manual_role_strap};
      sw_sync_q <= {sw_sync_q[0], switch_port_strap};
    end
  end

  // strap values are caught once, after the synchronisers have filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'b00;
    end else if (strap_cnt_q != (gan_pkg::STRAP_SETTLE + 2'b01)) begin
      strap_cnt_q <= strap_cnt_q + 2'b01;
    end
  end

  // load once the second flop holds the pin, not its reset value
  assign strap_load = (strap_cnt_q == gan_pkg::STRAP_SETTLE);

  // apb decode: capture at the first access edge, complete at the next
  assign access = psel & penable;
  assign take = access & !pready_q;
  assign done = access & pready_q;
  assign wr_np = done & pwrite & (paddr == gan_pkg::A_NP_TX);
  assign wr_gc = done & pwrite & (paddr == gan_pkg::A_GB_CTRL);
  assign wr_ec = done & pwrite & (paddr == gan_pkg::A_EXT_CTRL);
  // read side effects fire with data capture, so nothing is lost in between
  assign rd_stat = take & !pwrite & (paddr == gan_pkg::A_GB_STAT);

  always_comb begin
    stat_word = 16'h0000;
    stat_word[gan_pkg::GS_FAULT] = fault_q;
    stat_word[14] = rif.is_master;
    stat_word[13] = loc_rcvr_ok;
    stat_word[12] = rem_rcvr_ok;
    stat_word[11] = lp_adv_fdx;
    stat_word[10] = lp_adv_hdx;
    stat_word[7:0] = idle_cnt_q;
  end

  always_comb begin
    rdata_d = 16'h0000;
    hit_d = 1'b1;
    case (paddr)
      gan_pkg::A_NP_TX: begin
        rdata_d = np_tx_q;
      end
      gan_pkg::A_NP_RX: begin
        rdata_d = np_rx_q;
      end
      gan_pkg::A_GB_CTRL: begin
        rdata_d = gc_q & gan_pkg::GC_WMASK;
      end
      gan_pkg::A_GB_STAT: begin
        rdata_d = stat_word;
      end
      gan_pkg::A_EXT_STAT: begin
        rdata_d = gan_pkg::EXT_STAT_VAL;
      end
      gan_pkg::A_EXT_CTRL: begin
        rdata_d = ec_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // unmapped or misaligned addresses answer with an error and zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (take) begin
      pready_q <= 1'b1;
      pslverr_q <= !hit_d;
      prdata_q <= pwrite ? 32'h00000000 : {16'h0000, rdata_d};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // next page transmit; the toggle bit is owned by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_tx_q <= gan_pkg::NP_TX_RST;
    end else begin
      if (wr_np) begin
        np_tx_q <= masked(np_tx_q, merge(np_tx_q, pwdata, pstrb), gan_pkg::NP_TX_WMASK);
      end
      if (np_tx_taken) begin
        np_tx_q[gan_pkg::NP_TOG] <= !np_tx_q[gan_pkg::NP_TOG];
      end
    end
  end

  // partner page is copied whole when the engine accepts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_rx_q <= gan_pkg::NP_RX_RST;
    end else if (np_rx_valid) begin
      np_rx_q <= np_rx_word;
    end
  end

  // gigabit control; a strap load and a write never meet in practice,
  // since the first transfer starts after the straps settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_q <= gan_pkg::GC_RST;
    end else if (wr_gc) begin
      gc_q <= masked(gc_q, merge(gc_q, pwdata, pstrb), gan_pkg::GC_WMASK);
    end else if (strap_load) begin
      gc_q[gan_pkg::GC_MAN_EN] <= man_sync_q[1];
      gc_q[gan_pkg::GC_MAN_VAL] <= sw_sync_q[1];
      gc_q[gan_pkg::GC_SWITCH] <= sw_sync_q[1];
    end
  end

  // fault flag: a new fault wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (rif.fault) begin
      fault_q <= 1'b1;
    end else if (rd_stat || an_restart || rif.clean) begin
      fault_q <= 1'b0;
    end
  end

  assign idle_inc = idle_err & loc_rcvr_ok;

  // idle error counter; an error on the clearing read counts as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= gan_pkg::IDLE_RST;
    end else if (rd_stat) begin
      idle_cnt_q <= idle_inc ? 8'h01 : gan_pkg::IDLE_RST;
    end else if (idle_inc && (idle_cnt_q != gan_pkg::IDLE_MAX)) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  assign ec_wr_d = merge(ec_q, pwdata, pstrb);

  // extended control; scrambler reset bit is self-clearing and reads 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ec_q <= gan_pkg::EXT_CTRL_RST;
      scr_rst_q <= 1'b0;
    end else begin
      scr_rst_q <= wr_ec & ec_wr_d[gan_pkg::EC_SCR_RST];
      if (wr_ec) begin
        // reserved bits are stored as written; software keeps them intact
        ec_q <= masked(ec_q, ec_wr_d, gan_pkg::EXT_CTRL_WMASK);
      end
    end
  end

  // role resolution runs once per completed negotiation
  assign rif.resolve = an_complete;
  assign rif.loc_manual = gc_q[gan_pkg::GC_MAN_EN];
  assign rif.loc_value = gc_q[gan_pkg::GC_MAN_VAL];
  assign rif.loc_switch = gc_q[gan_pkg::GC_SWITCH];
  assign rif.loc_seed = loc_seed;
  assign rif.lp_manual = lp_manual;
  assign rif.lp_value = lp_value;
  assign rif.lp_switch = lp_switch;
  assign rif.lp_seed = lp_seed;

  role_resolver u_resolver (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif.res)
  );

  // outputs, each from a register
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign np_tx_word = np_tx_q;
  assign test_mode = gc_q[gan_pkg::GC_TM_LSB +: 3];
  assign role_manual = gc_q[gan_pkg::GC_MAN_EN];
  assign role_value = gc_q[gan_pkg::GC_MAN_VAL];
  assign switch_port = gc_q[gan_pkg::GC_SWITCH];
  assign adv_fdx = gc_q[gan_pkg::GC_ADV_FDX];
  assign adv_hdx = gc_q[gan_pkg::GC_ADV_HDX];
  assign is_master = rif.is_master;
  assign ext_ctrl = ec_q;
  assign scrambler_reset = scr_rst_q;

endmodule

//--- testbench/gigabit_copper_autoneg_regs_properties.sv
// Purpose: concurrent checks on the register group ports
// Assumes: one clock domain, reset active low
// Notes: read data is captured one edge before pready
`timescale 1ns/100ps
module gan_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic an_complete,
  input wire logic np_tx_taken,
  input wire logic lp_manual,
  input wire logic lp_switch,
  input wire logic lp_adv_fdx,
  input wire logic lp_adv_hdx,
  input wire logic loc_rcvr_ok,
  input wire logic rem_rcvr_ok,
  input wire logic [15:0] np_tx_word,
  input wire logic [2:0] test_mode,
  input wire logic role_manual,
  input wire logic role_value,
  input wire logic switch_port,
  input wire logic adv_fdx,
  input wire logic adv_hdx,
  input wire logic is_master
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ok(logic w, logic [17:0] a);
    pready && pwrite == w && !pslverr && paddr == a;
  endsequence
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error answer with data");
  property p_np;
    s_ok(1'b1, gan_pkg::A_NP_TX) ##0 pstrb[1:0] == 2'b11 |=>
      (np_tx_word & 16'hB7FF) == ($past(pwdata[15:0]) & 16'hB7FF);
  endproperty
  a_np: assert property (p_np) else $error("next page word not stored");
  property p_tog; np_tx_taken |=> np_tx_word[11] != $past(np_tx_word[11]); endproperty
  a_tog: assert property (p_tog) else $error("toggle did not flip");
  property p_tm; s_ok(1'b1, gan_pkg::A_GB_CTRL) ##0 pstrb[1] |=> test_mode == $past(pwdata[15:13]); endproperty
  a_tm: assert property (p_tm) else $error("test mode not stored");
  property p_adv;
    s_ok(1'b1, gan_pkg::A_GB_CTRL) ##0 pstrb[1] |=> {adv_fdx, adv_hdx} == $past(pwdata[9:8]);
  endproperty
  a_adv: assert property (p_adv) else $error("advertise bits not stored");
  property p_man; an_complete && role_manual && !lp_manual |=> is_master == $past(role_value); endproperty
  a_man: assert property (p_man) else $error("manual role ignored");
  property p_sw;
    an_complete && !role_manual && !lp_manual && switch_port != lp_switch |=> is_master == $past(switch_port);
  endproperty
  a_sw: assert property (p_sw) else $error("switch port not master");
  property p_live;
    s_ok(1'b0, gan_pkg::A_GB_STAT) |-> prdata[13:10] == $past({loc_rcvr_ok, rem_rcvr_ok, lp_adv_fdx, lp_adv_hdx});
  endproperty
  a_live: assert property (p_live) else $error("live status bits wrong");
  property p_ext; s_ok(1'b0, gan_pkg::A_EXT_STAT) |-> prdata == {16'h0000, gan_pkg::EXT_STAT_VAL}; endproperty
  a_ext: assert property (p_ext) else $error("capability word wrong");
  c_done: cover property (an_complete);
  c_err: cover property (pslverr);
  c_page: cover property (np_tx_taken);
endmodule
bind gigabit_copper_autoneg_regs gan_regs_checker i_chk (.*);

//--- testbench/link_partner_model.sv
// Purpose: far-end link partner and negotiation engine stand-in
// Assumes: pulses last one cycle, levels held between events
// Notes: page word is inverted after acceptance, never left stale
`timescale 1ns/100ps
module link_partner_model (
  input wire logic pclk,
  output logic an_restart,
  output logic an_complete,
  output logic np_tx_taken,
  output logic np_rx_valid,
  output logic [15:0] np_rx_word,
  output logic lp_manual,
  output logic lp_value,
  output logic lp_switch,
  output logic [10:0] lp_seed,
  output logic [10:0] loc_seed,
  output logic lp_adv_fdx,
  output logic lp_adv_hdx,
  output logic loc_rcvr_ok,
  output logic rem_rcvr_ok,
  output logic idle_err
);
  initial begin
    {an_restart, an_complete, np_tx_taken, np_rx_valid, idle_err} = 5'h00;
    {lp_manual, lp_value, lp_switch, lp_adv_fdx, lp_adv_hdx, loc_rcvr_ok, rem_rcvr_ok} = 7'h00;
    np_rx_word = 16'h0000;
    lp_seed = 11'h000;
    loc_seed = 11'h100;
  end
  task automatic page(input logic [15:0] w);
    @(posedge pclk);
    np_rx_word <= w;
    np_rx_valid <= 1'b1;
    np_tx_taken <= 1'b1;
    @(posedge pclk);
    np_rx_valid <= 1'b0;
    np_tx_taken <= 1'b0;
    np_rx_word <= ~w;
  endtask
  task automatic done(input logic m, input logic v, input logic s, input logic [10:0] sd);
    @(posedge pclk);
    {lp_manual, lp_value, lp_switch, lp_seed} <= {m, v, s, sd};
    an_complete <= 1'b1;
    @(posedge pclk);
    an_complete <= 1'b0;
  endtask
  task automatic restart;
    @(posedge pclk);
    an_restart <= 1'b1;
    @(posedge pclk);
    an_restart <= 1'b0;
  endtask
  task automatic seed(input logic [10:0] s);
    @(posedge pclk);
    loc_seed <= s;
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge pclk);
    {loc_rcvr_ok, rem_rcvr_ok, lp_adv_fdx, lp_adv_hdx} <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge pclk);
      idle_err <= 1'b1;
      @(posedge pclk);
      idle_err <= 1'b0;
    end
  endtask
endmodule

//--- testbench/gigabit_copper_autoneg_regs_test.sv
// Purpose: self-checking bench for the register group
// Assumes: one wait state per transfer, straps settle after reset
// Notes: strap readback and table rows first, then test modes, reset, paging, roles and idle count
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module gigabit_copper_autoneg_regs_test;
  typedef struct packed {logic [17:0] a; logic [15:0] d; logic [3:0] s; logic [15:0] x; logic e;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, manual_role_strap, switch_port_strap;
  logic an_restart, an_complete, np_tx_taken, np_rx_valid, lp_manual, lp_value, lp_switch, idle_err;
  logic lp_adv_fdx, lp_adv_hdx, loc_rcvr_ok, rem_rcvr_ok, scrambler_reset;
  logic role_manual, role_value, switch_port, adv_fdx, adv_hdx, is_master;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] np_rx_word, np_tx_word, ext_ctrl;
  logic [10:0] lp_seed, loc_seed;
  logic [2:0] test_mode;
  logic er;
  int num_errors = 0;
  int checks = 0;
  row_t rows [10] = '{
    '{gan_pkg::A_NP_TX, 16'hFFFF, 4'hF, 16'hB7FF, 1'b0},
    '{gan_pkg::A_NP_TX, 16'h0000, 4'h1, 16'hB700, 1'b0},
    '{gan_pkg::A_NP_TX, 16'h5A5A, 4'hF, 16'h125A, 1'b0},
    '{gan_pkg::A_GB_CTRL, 16'hFFFF, 4'hF, 16'hFF00, 1'b0},
    '{gan_pkg::A_NP_RX, 16'hFFFF, 4'hF, 16'h0000, 1'b0},
    '{gan_pkg::A_GB_STAT, 16'hFFFF, 4'hF, 16'h0000, 1'b0},
    '{gan_pkg::A_EXT_STAT, 16'h0000, 4'hF, 16'h3000, 1'b0},
    '{gan_pkg::A_EXT_CTRL, 16'hFFFF, 4'hF, 16'hFFBF, 1'b0},
    '{18'h3FFAC, 16'hFFFF, 4'hF, 16'h0000, 1'b1},
    '{18'h3FF9D, 16'hFFFF, 4'hF, 16'h0000, 1'b1}};
  gigabit_copper_autoneg_regs i_dut (.*);
  link_partner_model i_lp (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, ~d, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic rdchk(input logic [17:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000, 4'hF);
    `CHK(rd[15:0], x)
  endtask
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    manual_role_strap = 1'b0;
    switch_port_strap = 1'b1;
    reset_dut();
    rdchk(gan_pkg::A_GB_CTRL, 16'h0F00);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      apb(1'b0, rows[i].a, 16'h0000, 4'hF);
      `CHK({er, rd[15:0]}, {rows[i].e, rows[i].x})
    end
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, gan_pkg::A_GB_CTRL, {m[2:0], 13'h0300}, 4'hF);
      rdchk(gan_pkg::A_GB_CTRL, {m[2:0], 13'h0300});
    end
    $display("table and test modes done");
    manual_role_strap <= 1'b1;
    switch_port_strap <= 1'b0;
    reset_dut();
    rdchk(gan_pkg::A_NP_TX, 16'h2001);
    rdchk(gan_pkg::A_NP_RX, 16'h0000);
    rdchk(gan_pkg::A_GB_CTRL, 16'h1300);
    `CHK({test_mode, role_manual, role_value, switch_port, adv_fdx, adv_hdx}, 8'h13)
    rdchk(gan_pkg::A_GB_STAT, 16'h0000);
    rdchk(gan_pkg::A_EXT_CTRL, 16'h0000);
    apb(1'b1, gan_pkg::A_EXT_CTRL, 16'h8040, 4'hF);
    @(negedge pclk);
    `CHK({scrambler_reset, ext_ctrl}, {1'b1, 16'h8000})
    @(negedge pclk);
    `CHK(scrambler_reset, 1'b0)
    $display("reset values done");
    i_lp.page(16'hF9A5);
    rdchk(gan_pkg::A_NP_RX, 16'hF9A5);
    rdchk(gan_pkg::A_NP_TX, 16'h2801);
    i_lp.page(16'h0123);
    rdchk(gan_pkg::A_NP_RX, 16'h0123);
    rdchk(gan_pkg::A_NP_TX, 16'h2001);
    $display("next pages done");
    i_lp.lvl(4'hE);
    apb(1'b1, gan_pkg::A_GB_CTRL, 16'h1B00, 4'hF);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    i_lp.done(1'b1, 1'b1, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'hF800);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    i_lp.done(1'b1, 1'b1, 1'b0, 11'h005);
    i_lp.restart();
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    apb(1'b1, gan_pkg::A_GB_CTRL, 16'h0700, 4'hF);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    apb(1'b1, gan_pkg::A_GB_CTRL, 16'h0300, 4'hF);
    i_lp.done(1'b0, 1'b0, 1'b1, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h3800);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h005);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h100);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    i_lp.seed(11'h004);
    i_lp.done(1'b0, 1'b0, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h3800);
    i_lp.done(1'b1, 1'b0, 1'b0, 11'h005);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    $display("role resolution done");
    i_lp.lvl(4'h7);
    i_lp.idle(3);
    rdchk(gan_pkg::A_GB_STAT, 16'h5C00);
    i_lp.lvl(4'hE);
    i_lp.idle(3);
    rdchk(gan_pkg::A_GB_STAT, 16'h7803);
    rdchk(gan_pkg::A_GB_STAT, 16'h7800);
    i_lp.idle(260);
    rdchk(gan_pkg::A_GB_STAT, 16'h78FF);
    $display("idle count done");
    complete_run();
  end
endmodule
